/* hw/clk_half_div.v */
// Divide-by-two output stage with stop gating
`timescale 1ns/1ps
`default_nettype none
module clk_half_div (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Control
  input wire run_i,
  // Output
  output reg half_o
);
  always @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      half_o <= 1'b0;
    end else begin
      half_o <= ~half_o;
    end
  end
endmodule // clk_half_div
`default_nettype wire

/* hw/clkgen_consts.vh */
// Constants for the clock generator control block
// What this block does
// - Divider select ignores writes while PLL on
// - Divider select zero behaves as one
// - Divider select resets to one
// - Upper four select bits read zero
// - Auto mode: lock edges raise interrupt request
// - Interrupt forwarded only when enable set
// - Flag sets regardless of enable
// - Manual mode blocks interrupt, flag reads zero
// - VCO source selectable while unlocked
// - Wait leaves clock generator unchanged
// - Stop without osc option kills oscillator, PLL power, clocks and interrupt
// - Stop clears base clock select
// - Select stays clear after stop recovery
// - Stop with osc option keeps oscillator
// - Break with clear disabled protects flag
// - Break with clear enabled allows clearing
// - Lock reads live only in auto mode
// - Select picks VCO or crystal halved
`ifndef CLKGEN_CONSTS_VH
`define CLKGEN_CONSTS_VH
// ==========================================
// Register offsets
`define ADDR_PLL_CONTROL 4'h0
`define ADDR_PLL_BANDWIDTH 4'h1
`define ADDR_REF_DIV_SEL 4'h2
`define ADDR_SYS_CONFIG 4'h3
// ==========================================
// Control register fields
`define CTL_IRQ_EN_BIT 7
`define CTL_FLAG_BIT 6
`define CTL_PWR_BIT 5
`define CTL_BCS_BIT 4
// ==========================================
// Bandwidth register fields
`define BW_AUTO_BIT 7
`define BW_LOCK_BIT 6
// ==========================================
// Config register fields
`define CFG_OSC_STOP_BIT 0
`define CFG_BRK_CLR_BIT 1
// ==========================================
// Reset values
`define REF_DIV_RESET 4'h1
`define REF_DIV_ONE 4'h1
`endif

/* hw/pll_refdiv_irq_lowpower_ctrl.v */
// Control logic around the clock generator PLL
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_consts.vh"
module pll_refdiv_irq_lowpower_ctrl (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // PLL analog side
  input wire lock_raw_i,
  input wire vco_tick_i,
  output reg pll_power_enable_o,
  output reg osc_enable_o,
  output reg [3:0] ref_divide_factor_o,
  // System side
  input wire stop_i,
  input wire wait_i,
  input wire break_i,
  output reg crystal_clock_en_o,
  output wire generated_output_clock_o,
  output reg clockgen_irq_out_o
);
  // ==========================================
  // Synchronisers for pins from the analog side
  reg lock_s1_reg;
  reg lock_s2_reg;
  reg vco_s1_reg;
  reg vco_s2_reg;
  reg lock_prev_reg;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
      vco_s1_reg <= 1'b0;
      vco_s2_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
    end else begin
      lock_s1_reg <= lock_raw_i;
      lock_s2_reg <= lock_s1_reg;
      vco_s1_reg <= vco_tick_i;
      vco_s2_reg <= vco_s1_reg;
      lock_prev_reg <= lock_s2_reg;
    end
  end
  // ==========================================
  // Registers
  reg irq_en_reg;
  reg flag_reg;
  reg pwr_reg;
  reg bcs_reg;
  reg auto_reg;
  reg osc_stop_reg;
  reg brk_clr_reg;
  reg [3:0] ref_div_reg;
  reg flag_next;
  wire lock_vis;
  wire lock_edge;
  wire wr_ctl;
  wire sel_vco;
  assign lock_vis = auto_reg & lock_s2_reg;
  assign lock_edge = auto_reg & (lock_s2_reg ^ lock_prev_reg);
  assign wr_ctl = wr_i && (addr_i == `ADDR_PLL_CONTROL);
  // Stop-in-progress forces crystal source
  assign sel_vco = bcs_reg & ~stop_i;
  // Flag: set wins over clear; break guards the clear
  always @* begin
    flag_next = flag_reg;
    if (wr_ctl && !wdata_i[`CTL_FLAG_BIT] && (!break_i || brk_clr_reg)) begin
      flag_next = 1'b0;
    end
    if (lock_edge) begin
      flag_next = 1'b1;
    end
    if (!auto_reg) begin
      flag_next = 1'b0;
    end
  end
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_en_reg <= 1'b0;
      flag_reg <= 1'b0;
      pwr_reg <= 1'b0;
      bcs_reg <= 1'b0;
      auto_reg <= 1'b0;
      osc_stop_reg <= 1'b0;
      brk_clr_reg <= 1'b0;
      ref_div_reg <= `REF_DIV_RESET;
    end else begin
      flag_reg <= flag_next;
      if (wr_ctl) begin
        irq_en_reg <= wdata_i[`CTL_IRQ_EN_BIT];
        // Power cannot drop while VCO selected
        pwr_reg <= wdata_i[`CTL_PWR_BIT] | bcs_reg;
        // Lock not required to select VCO; power is
        bcs_reg <= wdata_i[`CTL_BCS_BIT] & pwr_reg;
      end
      if (wr_i && addr_i == `ADDR_PLL_BANDWIDTH) begin
        auto_reg <= wdata_i[`BW_AUTO_BIT];
      end
      if (wr_i && addr_i == `ADDR_REF_DIV_SEL && !pwr_reg) begin
        ref_div_reg <= wdata_i[3:0];
      end
      if (wr_i && addr_i == `ADDR_SYS_CONFIG) begin
        osc_stop_reg <= wdata_i[`CFG_OSC_STOP_BIT];
        brk_clr_reg <= wdata_i[`CFG_BRK_CLR_BIT];
      end
      // Wait input deliberately unused: nothing changes
      if (stop_i) begin
        bcs_reg <= 1'b0;
      end
    end
  end
  // ==========================================
  // Read port
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ADDR_PLL_CONTROL: rdata_o <= {irq_en_reg, flag_reg & auto_reg, pwr_reg,
          bcs_reg, 4'h0};
        `ADDR_PLL_BANDWIDTH: rdata_o <= {auto_reg, lock_vis, 6'h00};
        `ADDR_REF_DIV_SEL: rdata_o <= {4'h0, ref_div_reg};
        `ADDR_SYS_CONFIG: rdata_o <= {6'h00, brk_clr_reg, osc_stop_reg};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
  // ==========================================
  // Outputs to analog and system
  wire osc_run;
  assign osc_run = ~stop_i | osc_stop_reg;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pll_power_enable_o <= 1'b0;
      osc_enable_o <= 1'b0;
      ref_divide_factor_o <= `REF_DIV_ONE;
      crystal_clock_en_o <= 1'b0;
      clockgen_irq_out_o <= 1'b0;
    end else begin
      pll_power_enable_o <= pwr_reg & ~stop_i;
      osc_enable_o <= osc_run;
      crystal_clock_en_o <= osc_run;
      ref_divide_factor_o <= (ref_div_reg == 4'h0) ? `REF_DIV_ONE : ref_div_reg;
      clockgen_irq_out_o <= flag_next & irq_en_reg & auto_reg & ~stop_i;
    end
  end
  // ==========================================
  // Output clock: halved crystal or halved VCO tick
  wire xtal_half;
  wire vco_half;
  reg vco_half_reg;
  clk_half_div u_xtal_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(~stop_i),
    .half_o(xtal_half)
  );
  always @(posedge clk_i) begin
    if (!rst_n_i || stop_i) begin
      vco_half_reg <= 1'b0;
    end else if (vco_s2_reg) begin
      vco_half_reg <= ~vco_half_reg;
    end
  end
  assign vco_half = vco_half_reg;
  assign generated_output_clock_o = sel_vco ? vco_half : xtal_half;
endmodule // pll_refdiv_irq_lowpower_ctrl
`default_nettype wire

/* test/clkgen_ctrl_asserts.sv */
// Port checker for the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module clkgen_ctrl_asserts (
  input wire clk_i, rst_n_i, rd_i, stop_i,
  input wire [3:0] addr_i, ref_divide_factor_o,
  input wire [7:0] rdata_o,
  input wire pll_power_enable_o, generated_output_clock_o, clockgen_irq_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========
  // Stop mode
  stop_pll_off_a: assert property (stop_i [*2] |-> !pll_power_enable_o)
    else $error("pll on in stop");
  stop_irq_low_a: assert property (stop_i [*2] |-> !clockgen_irq_out_o)
    else $error("irq in stop");
  stop_out_low_a: assert property (stop_i [*3] |-> !generated_output_clock_o)
    else $error("clock out in stop");
  stop_bcs_clr_a:
    assert property (stop_i [*2] ##0 (rd_i && addr_i == 4'h0) |=> !rdata_o[4])
    else $error("select set in stop");
  // ==========
  // Divider; one cycle of latency, so three cycles of power give margin
  div_nonzero_a: assert property (ref_divide_factor_o != 4'h0)
    else $error("divider zero");
  div_reset_a: assert property ($rose(rst_n_i) |-> ref_divide_factor_o == 4'h1)
    else $error("divider reset");
  div_locked_a: assert property (pll_power_enable_o [*3] |=> $stable(ref_divide_factor_o))
    else $error("divider moved");
  div_top_zero_a: assert property (rd_i && addr_i == 4'h2 |=> rdata_o[7:4] == 4'h0)
    else $error("upper bits set");
  cover property (stop_i [*3]);
  cover property (clockgen_irq_out_o);
  cover property (rd_i && addr_i == 4'h2);
endmodule // clkgen_ctrl_asserts
bind pll_refdiv_irq_lowpower_ctrl clkgen_ctrl_asserts clkgen_ctrl_asserts_i (.*);
`default_nettype wire

/* test/pll_far_model.sv */
// Far-side model: PLL loop lock and VCO activity
`timescale 1ns/1ps
`default_nettype none
module pll_far_model (
  input wire clk_i, rst_n_i, power_i, lock_cmd_i,
  output logic lock_raw_o, vco_tick_o
);
  // Lock only shows while the loop is powered
  always @(posedge clk_i) begin
    lock_raw_o <= rst_n_i & power_i & lock_cmd_i;
    vco_tick_o <= rst_n_i & power_i;
  end
endmodule // pll_far_model
`default_nettype wire

/* test/test_pll_refdiv_irq_lowpower_ctrl.sv */
// Testbench for the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module test_pll_refdiv_irq_lowpower_ctrl;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, lock_cmd = 1'b0;
  logic stop_i = 1'b0, wait_i = 1'b0, break_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  wire [7:0] rdata_o;
  wire [3:0] ref_divide_factor_o;
  wire lock_raw_i, vco_tick_i, pll_power_enable_o, osc_enable_o, crystal_clock_en_o;
  wire generated_output_clock_o, clockgen_irq_out_o;
  int num_errors = 0;
  int checks = 0;
  pll_refdiv_irq_lowpower_ctrl pll_refdiv_irq_lowpower_ctrl_i (.*);
  pll_far_model pll_far_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .power_i(pll_power_enable_o), .lock_cmd_i(lock_cmd),
    .lock_raw_o(lock_raw_i), .vco_tick_o(vco_tick_i));
  initial forever #2.5 clk_i = ~clk_i;
  // ==========
  // Bus and compare tasks
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // Bounded wait; a timeout shows up as a mismatch
  task wait_irq(input logic v);
    for (int n = 0; n < 20 && clockgen_irq_out_o !== v; n++) @(posedge clk_i);
    chk({7'h00, clockgen_irq_out_o}, {7'h00, v});
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    give_verdict;
  end
  // ==========
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(4'h2, 8'h01);
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h00);
    chk({4'h0, ref_divide_factor_o}, 8'h01);
    wr(4'h2, 8'hf5);
    rd(4'h2, 8'h05);
    chk({4'h0, ref_divide_factor_o}, 8'h05);
    wr(4'h1, 8'h80);
    wr(4'h0, 8'ha0);
    wr(4'h2, 8'h03);
    rd(4'h2, 8'h05);
    rd(4'h1, 8'h80);
    lock_cmd <= 1'b1;
    wait_irq(1'b1);
    rd(4'h1, 8'hc0);
    wr(4'h0, 8'hf0);
    break_i <= 1'b1;
    wr(4'h0, 8'hb0);
    rd(4'h0, 8'hf0);
    wr(4'h3, 8'h02);
    wr(4'h0, 8'hb0);
    break_i <= 1'b0;
    rd(4'h0, 8'hb0);
    wait_irq(1'b0);
    wr(4'h0, 8'h30);
    lock_cmd <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(4'h0, 8'h70);
    wait_irq(1'b0);
    wr(4'h1, 8'h00);
    wait_i <= 1'b1;
    rd(4'h0, 8'h30);
    wait_i <= 1'b0;
    wr(4'h3, 8'h01);
    stop_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk({6'h00, osc_enable_o, pll_power_enable_o}, 8'h02);
    rd(4'h0, 8'h20);
    stop_i <= 1'b0;
    rd(4'h0, 8'h20);
    wr(4'h3, 8'h00);
    stop_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk({5'h00, osc_enable_o, crystal_clock_en_o, generated_output_clock_o}, 8'h00);
    give_verdict;
  end
endmodule // test_pll_refdiv_irq_lowpower_ctrl
`default_nettype wire
